// ==== inc/tlv_pkg.sv ====
// Constants and carrier types for the two-level vectored interrupt unit.
// Assumes one clk edge per machine cycle of the processor core.
`default_nettype none
package tlv_pkg;
    // ****************************************
    // Register map (byte offsets, one word each)
    // ****************************************
    localparam logic [7:0] OFS_FLAG    = 8'h00;
    localparam logic [7:0] OFS_ENABLE  = 8'h04;
    localparam logic [7:0] OFS_PRIO    = 8'h08;
    localparam logic [7:0] OFS_CONFIG  = 8'h0C;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    localparam logic [7:0] OFS_WDCTRL  = 8'h14;
    // ****************************************
    // Flag register bit positions
    // ****************************************
    localparam int FLAG_W    = 15;
    localparam int FB_EXT0   = 0;
    localparam int FB_T0     = 1;
    localparam int FB_EXT1   = 2;
    localparam int FB_T1     = 3;
    localparam int FB_S0RX   = 4;
    localparam int FB_S0TX   = 5;
    localparam int FB_T2OVF  = 6;
    localparam int FB_T2CAP  = 7;
    localparam int FB_S1RX   = 8;
    localparam int FB_S1TX   = 9;
    localparam int FB_EXT2   = 10;
    localparam int FB_WDT    = 14;
    // ****************************************
    // Enable, priority, config, watchdog fields
    // ****************************************
    localparam int EN_W        = 17;
    localparam int PR_W        = 13;
    localparam int EN_GLOBAL   = 7;
    localparam int EN_PFI      = 16;
    localparam int CFG_W       = 6;
    localparam int CFG_TRIG0   = 0;
    localparam int CFG_TRIG1   = 1;
    localparam int CFG_HC_LO   = 2;
    localparam int WD_FLAG_BIT = 3;
    localparam logic [FLAG_W-1:0] FLAG_RST   = 15'h0000;
    localparam logic [EN_W-1:0]   ENABLE_RST = 17'h00000;
    localparam logic [PR_W-1:0]   PRIO_RST   = 13'h0000;
    localparam logic [CFG_W-1:0]  CFG_RST    = 6'h00;
    // ****************************************
    // Sources, levels, vectors, call timing
    // ****************************************
    localparam int NSRC     = 12;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_T0   = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_T1   = 3;
    localparam int SRC_EXT2 = 7;
    localparam logic [1:0] LVL_NONE    = 2'h0;
    localparam logic [1:0] LVL_LOW     = 2'h1;
    localparam logic [1:0] LVL_HIGH    = 2'h2;
    localparam logic [1:0] LVL_HIGHEST = 2'h3;
    localparam int         CALL_CYCLES = 4;
    localparam logic [1:0] CALL_LAST   = 2'(CALL_CYCLES - 1);
    localparam logic [15:0] PFI_VECTOR = 16'h006B;
    localparam logic [15:0] VECTOR [NSRC] = '{
        16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
        16'h003B, 16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063};
    // ****************************************
    // Carrier structs
    // ****************************************
    typedef struct packed {
        logic timer0_ovf;
        logic timer1_ovf;
        logic timer2_ovf;
        logic timer2_cap;
        logic serial0_rx;
        logic serial0_tx;
        logic serial1_rx;
        logic serial1_tx;
        logic watchdog_timeout;
    } tlv_events_t;
    typedef struct packed {
        logic        last_cycle;
        logic        writes_irq_regs;
        logic        is_return_from_irq;
        logic [15:0] pc;
    } tlv_core_in_t;
    typedef struct packed {
        logic        active;
        logic        push;
        logic        load;
        logic [15:0] push_pc;
        logic [15:0] vector;
    } tlv_call_out_t;
endpackage
`default_nettype wire

// ==== core/tlv_irq_ctrl.sv ====
// Two-level vectored interrupt controller with Avalon-MM register slave.
// Assumes clk is the machine-cycle clock and all inputs are synchronous.
//
// Notes on behaviour
// (R1) Twelve sources, each flag, enable, priority, vector
// (R2) External 0/1 edge or level by select
// (R3) Edge: high sample then low sets flag
// (R4) Requester holds pin levels one full cycle
// (R5) Edge-mode external 0/1 flags cleared on vectoring
// (R6) Level mode: flag follows pin, never cleared
// (R7) External 2-5 edge only; optional hardware clear
// (R8) Timer 0/1 flags cleared on vectoring
// (R9) Timer 2 request ORs two flags, no clear
// (R10) Watchdog flag at control bit 3, enable 4; here its enable is ENABLE bit 12
// (R11) Serial requests OR rx/tx, never hardware cleared
// (R12) Software writes flags like hardware set/clear
// (R13) Global enable masks all but power-fail
// (R14) Two levels plus highest; no lower preemption
// (R15) Ties resolved by fixed source order
// (R16) Sample, poll, resolve every machine cycle
// (R17) Call only when three conditions hold
// (R18) Denied requests are not remembered
// (R19) Push PC, no status word, load vector
// (R20) Fixed vector address per source
// (R21) Return-from-irq ends service; plain return not
// (R22) Pins sampled each cycle; call takes four cycles
// (R23) One in-service bit per level blocks acceptance
`timescale 1ns/1ps
`default_nettype none
module tlv_irq_ctrl
    import tlv_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic [7:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic      [31:0]   avs_readdata,
    output logic               avs_waitrequest,
    input  wire logic [5:0]    ext_request_pin_n,
    input  wire tlv_events_t   events_i,
    input  wire logic          power_fail_irq,
    input  wire tlv_core_in_t  core_i,
    output tlv_call_out_t      call_o
);
    typedef enum logic {ST_IDLE, ST_CALL} tlv_state_t;

    // ****************************************
    // State
    // ****************************************
    logic [FLAG_W-1:0] flag_reg,     flag_next;
    logic [EN_W-1:0]   enable_reg,   enable_next;
    logic [PR_W-1:0]   prio_reg,     prio_next;
    logic [CFG_W-1:0]  cfg_reg,      cfg_next;
    logic [5:0]        pin_prev_reg, pin_prev_next;
    logic [2:0]        insvc_reg,    insvc_next;
    tlv_state_t        state_reg,    state_next;
    logic [1:0]        cnt_reg,      cnt_next;
    logic [15:0]       vec_reg,      vec_next;
    logic [15:0]       pushpc_reg,   pushpc_next;
    logic              ack_reg,      ack_next;
    logic [31:0]       rdata_reg,    rdata_next;

    logic              bus_req;
    logic              wr_hit;
    logic [31:0]       be_mask;
    logic [31:0]       rd_mux;
    logic [5:0]        pin_edge;
    logic [FLAG_W-1:0] flag_set;
    logic [FLAG_W-1:0] flag_clr;
    logic [FLAG_W-1:0] flag_sw;
    logic [NSRC-1:0]   src_flag;
    logic [NSRC-1:0]   src_en;
    logic [NSRC-1:0]   src_hi;
    logic [NSRC-1:0]   src_req;
    logic              pfi_req;
    logic [1:0]        win_lvl;
    logic [3:0]        win_idx;
    logic              win_pfi;
    logic [1:0]        active_lvl;
    logic              poll_ok;
    logic              accept;

    // ****************************************
    // Avalon slave: one wait cycle per access
    // ****************************************
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_reg;
    assign wr_hit          = avs_write & ack_reg;
    assign be_mask         = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign avs_readdata    = rdata_reg;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            OFS_FLAG:   rd_mux[FLAG_W-1:0] = flag_reg;
            OFS_ENABLE: rd_mux[EN_W-1:0]   = enable_reg;
            OFS_PRIO:   rd_mux[PR_W-1:0]   = prio_reg;
            OFS_CONFIG: rd_mux[CFG_W-1:0]  = cfg_reg;
            OFS_STATUS: begin
                rd_mux[2:0]   = insvc_reg;
                rd_mux[3]     = (state_reg == ST_CALL);
                rd_mux[4]     = pfi_req;
                rd_mux[27:16] = src_req;
            end
            OFS_WDCTRL: rd_mux[WD_FLAG_BIT] = flag_reg[FB_WDT];
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        ack_next   = bus_req & ~ack_reg;
        rdata_next = rdata_reg;
        if (avs_read && !ack_reg) begin
            rdata_next = rd_mux;
        end
        enable_next = enable_reg;
        prio_next   = prio_reg;
        cfg_next    = cfg_reg;
        if (wr_hit) begin
            case (avs_address)
                OFS_ENABLE: enable_next = (enable_reg & ~be_mask[EN_W-1:0])
                              | (avs_writedata[EN_W-1:0] & be_mask[EN_W-1:0]);
                OFS_PRIO:   prio_next = (prio_reg & ~be_mask[PR_W-1:0])
                              | (avs_writedata[PR_W-1:0] & be_mask[PR_W-1:0]);
                OFS_CONFIG: cfg_next = (cfg_reg & ~be_mask[CFG_W-1:0])
                              | (avs_writedata[CFG_W-1:0] & be_mask[CFG_W-1:0]);
                default:    cfg_next = cfg_reg;
            endcase
        end
    end

    // ****************************************
    // Pin sampling and flag update
    // ****************************************
    always_comb begin
        pin_prev_next = ext_request_pin_n;
        pin_edge      = pin_prev_reg & ~ext_request_pin_n; // R3 R22
    end

    always_comb begin
        flag_sw = flag_reg;
        if (wr_hit && avs_address == OFS_FLAG) begin
            flag_sw = (flag_reg & ~be_mask[FLAG_W-1:0])
                    | (avs_writedata[FLAG_W-1:0] & be_mask[FLAG_W-1:0]); // R12
        end
        if (wr_hit && avs_address == OFS_WDCTRL && avs_byteenable[0]) begin
            flag_sw[FB_WDT] = avs_writedata[WD_FLAG_BIT]; // R10
        end
        flag_set = FLAG_RST;
        flag_set[FB_EXT0]  = cfg_reg[CFG_TRIG0] & pin_edge[0]; // R2 R3
        flag_set[FB_EXT1]  = cfg_reg[CFG_TRIG1] & pin_edge[1];
        flag_set[FB_EXT2+3:FB_EXT2] = pin_edge[5:2]; // R7
        flag_set[FB_T0]    = events_i.timer0_ovf;
        flag_set[FB_T1]    = events_i.timer1_ovf;
        flag_set[FB_T2OVF] = events_i.timer2_ovf;
        flag_set[FB_T2CAP] = events_i.timer2_cap;
        flag_set[FB_S0RX]  = events_i.serial0_rx;
        flag_set[FB_S0TX]  = events_i.serial0_tx;
        flag_set[FB_S1RX]  = events_i.serial1_rx;
        flag_set[FB_S1TX]  = events_i.serial1_tx;
        flag_set[FB_WDT]   = events_i.watchdog_timeout; // R10
        // Clear on vectoring; serial, timer 2, watchdog never
        flag_clr = FLAG_RST;
        if (accept && !win_pfi) begin
            case (win_idx)
                4'(SRC_EXT0): flag_clr[FB_EXT0] = cfg_reg[CFG_TRIG0]; // R5
                4'(SRC_EXT1): flag_clr[FB_EXT1] = cfg_reg[CFG_TRIG1]; // R5
                4'(SRC_T0):   flag_clr[FB_T0]   = 1'b1; // R8
                4'(SRC_T1):   flag_clr[FB_T1]   = 1'b1; // R8
                4'(SRC_EXT2):     flag_clr[FB_EXT2]   = cfg_reg[CFG_HC_LO];
                4'(SRC_EXT2 + 1): flag_clr[FB_EXT2+1] = cfg_reg[CFG_HC_LO+1];
                4'(SRC_EXT2 + 2): flag_clr[FB_EXT2+2] = cfg_reg[CFG_HC_LO+2];
                4'(SRC_EXT2 + 3): flag_clr[FB_EXT2+3] = cfg_reg[CFG_HC_LO+3];
                default:      flag_clr = FLAG_RST; // R9 R11
            endcase
        end
        // Hardware set wins over any clear in the same cycle
        flag_next = (flag_sw & ~flag_clr) | flag_set;
        if (!cfg_reg[CFG_TRIG0]) begin
            flag_next[FB_EXT0] = ~ext_request_pin_n[0]; // R6
        end
        if (!cfg_reg[CFG_TRIG1]) begin
            flag_next[FB_EXT1] = ~ext_request_pin_n[1]; // R6
        end
    end

    // ****************************************
    // Poll and priority resolution
    // ****************************************
    always_comb begin
        src_flag = {flag_reg[FB_WDT], flag_reg[FB_EXT2+3:FB_EXT2],
                    flag_reg[FB_S1RX] | flag_reg[FB_S1TX],
                    flag_reg[FB_T2OVF] | flag_reg[FB_T2CAP],
                    flag_reg[FB_S0RX] | flag_reg[FB_S0TX],
                    flag_reg[FB_T1], flag_reg[FB_EXT1],
                    flag_reg[FB_T0], flag_reg[FB_EXT0]}; // R1 R9 R11
        src_en  = {enable_reg[12:8], enable_reg[6:0]};
        src_hi  = {prio_reg[12:8], prio_reg[6:0]};
        src_req = src_flag & src_en & {NSRC{enable_reg[EN_GLOBAL]}}; // R13
        pfi_req = power_fail_irq & enable_reg[EN_PFI]; // R13
    end

    always_comb begin
        win_lvl = LVL_NONE;
        win_idx = 4'h0;
        win_pfi = 1'b0;
        // Downward scan with >= lets the earlier source win ties
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (src_req[i] && (src_hi[i] ? LVL_HIGH : LVL_LOW) >= win_lvl) begin
                win_lvl = src_hi[i] ? LVL_HIGH : LVL_LOW; // R14 R15
                win_idx = 4'(i);
            end
        end
        if (pfi_req) begin
            win_lvl = LVL_HIGHEST; // R14
            win_pfi = 1'b1;
        end
        if (insvc_reg[2]) begin
            active_lvl = LVL_HIGHEST;
        end else if (insvc_reg[1]) begin
            active_lvl = LVL_HIGH;
        end else if (insvc_reg[0]) begin
            active_lvl = LVL_LOW;
        end else begin
            active_lvl = LVL_NONE;
        end
        poll_ok = (state_reg == ST_IDLE) && core_i.last_cycle
                && !core_i.writes_irq_regs && !core_i.is_return_from_irq; // R17
        accept  = poll_ok && (win_lvl > active_lvl); // R16 R18 R23
    end

    // ****************************************
    // In-service tracking and hardware call
    // ****************************************
    always_comb begin
        insvc_next = insvc_reg;
        if (accept) begin
            insvc_next[win_lvl - 2'h1] = 1'b1; // R23
        end else if (core_i.is_return_from_irq && core_i.last_cycle) begin
            if (insvc_reg[2]) begin
                insvc_next[2] = 1'b0; // R21
            end else if (insvc_reg[1]) begin
                insvc_next[1] = 1'b0;
            end else begin
                insvc_next[0] = 1'b0;
            end
        end
    end

    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        vec_next    = vec_reg;
        pushpc_next = pushpc_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    state_next  = ST_CALL;
                    cnt_next    = 2'h0;
                    pushpc_next = core_i.pc; // R19
                    vec_next    = win_pfi ? PFI_VECTOR : VECTOR[win_idx]; // R20
                end
            end
            ST_CALL: begin
                if (cnt_reg == CALL_LAST) begin
                    state_next = ST_IDLE; // R22
                end else begin
                    cnt_next = cnt_reg + 2'h1;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_comb begin
        call_o.active  = (state_reg == ST_CALL);
        call_o.push    = (state_reg == ST_CALL) && (cnt_reg == 2'h0); // R19
        call_o.load    = (state_reg == ST_CALL) && (cnt_reg == CALL_LAST);
        call_o.push_pc = pushpc_reg;
        call_o.vector  = vec_reg;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_reg     <= FLAG_RST;
            enable_reg   <= ENABLE_RST;
            prio_reg     <= PRIO_RST;
            cfg_reg      <= CFG_RST;
            pin_prev_reg <= 6'h3F;
            insvc_reg    <= 3'h0;
            state_reg    <= ST_IDLE;
            cnt_reg      <= 2'h0;
            vec_reg      <= 16'h0000;
            pushpc_reg   <= 16'h0000;
            ack_reg      <= 1'b0;
            rdata_reg    <= 32'h0000_0000;
        end else begin
            flag_reg     <= flag_next;
            enable_reg   <= enable_next;
            prio_reg     <= prio_next;
            cfg_reg      <= cfg_next;
            pin_prev_reg <= pin_prev_next;
            insvc_reg    <= insvc_next;
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            vec_reg      <= vec_next;
            pushpc_reg   <= pushpc_next;
            ack_reg      <= ack_next;
            rdata_reg    <= rdata_next;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_edge_sets_flag: assert property (@(posedge clk) disable iff (!arst_n)
        cfg_reg[CFG_TRIG0] && pin_prev_reg[0] && !ext_request_pin_n[0]
        |=> flag_reg[FB_EXT0]) // R3
        else $error("edge on external 0 did not set its flag");

    a_level_no_clear: assert property (@(posedge clk) disable iff (!arst_n)
        accept && !win_pfi && win_idx == 4'(SRC_EXT0) && !cfg_reg[CFG_TRIG0]
        && !ext_request_pin_n[0] |=> flag_reg[FB_EXT0]) // R6
        else $error("level external 0 flag cleared while pin low");

    a_timer_clear: assert property (@(posedge clk) disable iff (!arst_n)
        accept && !win_pfi && win_idx == 4'(SRC_T0) && !events_i.timer0_ovf
        |=> !flag_reg[FB_T0]) // R8
        else $error("timer 0 flag not cleared on vectoring");

    a_timer2_keep: assert property (@(posedge clk) disable iff (!arst_n)
        accept && !win_pfi && win_idx == 4'h5 && flag_reg[FB_T2OVF] && !wr_hit
        |=> flag_reg[FB_T2OVF]) // R9
        else $error("timer 2 flag cleared by vectoring");

    a_serial_keep: assert property (@(posedge clk) disable iff (!arst_n)
        accept && !win_pfi && win_idx == 4'h4 && flag_reg[FB_S0RX] && !wr_hit
        |=> flag_reg[FB_S0RX]) // R11
        else $error("serial 0 flag cleared by hardware");

    a_sw_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
        wr_hit && avs_address == OFS_FLAG && avs_byteenable[0]
        && avs_writedata[FB_S0RX] |=> flag_reg[FB_S0RX]) // R12
        else $error("software write did not set serial 0 flag");

    a_global_mask: assert property (@(posedge clk) disable iff (!arst_n)
        !enable_reg[EN_GLOBAL] && !pfi_req |-> !accept) // R13
        else $error("call taken while globally disabled");

    a_no_preempt: assert property (@(posedge clk) disable iff (!arst_n)
        insvc_reg[1] && !pfi_req |-> !accept) // R14 R23
        else $error("high level service preempted");

    a_call_length: assert property (@(posedge clk) disable iff (!arst_n)
        accept |=> call_o.active [*4] ##1 !call_o.active) // R22
        else $error("hardware call not four cycles long");

    a_vector_load: assert property (@(posedge clk) disable iff (!arst_n)
        accept && !win_pfi |=> call_o.push && call_o.push_pc == $past(core_i.pc)
        && call_o.vector == VECTOR[$past(win_idx)]) // R19 R20
        else $error("wrong vector or pushed pc");

    a_blocked_call: assert property (@(posedge clk) disable iff (!arst_n)
        core_i.writes_irq_regs || core_i.is_return_from_irq || !core_i.last_cycle
        |=> !call_o.push) // R17
        else $error("call started in a blocked cycle");

    a_return_from_irq_ends: assert property (@(posedge clk) disable iff (!arst_n)
        core_i.is_return_from_irq && core_i.last_cycle && insvc_reg == 3'h1
        |=> insvc_reg == 3'h0) // R21
        else $error("return did not end service");

    a_bus_answer: assert property (@(posedge clk) disable iff (!arst_n)
        bus_req |-> ##[0:1] !avs_waitrequest)
        else $error("bus access not answered in one cycle");
endmodule
`default_nettype wire

// ==== bench/tlv_core_model.sv ====
// Processor core model facing the interrupt controller's call side.
// Assumes one clk edge per machine cycle; the bench steers its status.
`timescale 1ns/1ps
`default_nettype none
module tlv_core_model
    import tlv_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire tlv_call_out_t call_i,
    input  wire logic          stall,
    input  wire logic          wr_regs,
    input  wire logic          return_from_irq,
    output var  tlv_core_in_t  core_o,
    output var  logic [15:0]   pc_seen
);
    always_comb begin
        core_o.last_cycle      = !stall;
        core_o.writes_irq_regs = wr_regs;
        core_o.is_return_from_irq         = return_from_irq;
        core_o.pc              = 16'h1234;
    end
    // Stack push seen by the core
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_seen <= 16'h0000;
        end else if (call_i.push) begin
            pc_seen <= call_i.push_pc;
        end
    end
endmodule
`default_nettype wire

// ==== bench/tlv_irq_ctrl_tb.sv ====
// Self-checking bench for the interrupt controller.
// Assumes the controller's one-wait Avalon slave and the core model.
`timescale 1ns/1ps
`default_nettype none
module tlv_irq_ctrl_tb
    import tlv_pkg::*;
;
    logic          clk = 1'b0;
    logic          arst_n = 1'b0;
    logic [7:0]    adr = 8'h00;
    logic          rd = 1'b0;
    logic          wr = 1'b0;
    logic [31:0]   wd = 32'h0;
    logic [31:0]   rdq;
    logic [31:0]   rdat;
    logic          wq;
    logic [5:0]    pin_n = 6'h3F;
    tlv_events_t   ev = '0;
    logic          pf = 1'b0;
    logic          stall = 1'b0;
    logic          wrr = 1'b0;
    logic          return_from_irq = 1'b0;
    tlv_core_in_t  core;
    tlv_call_out_t call;
    logic [15:0]   pcs;
    int            bad_count = 0;
    int            checks = 0;
    int            n;
    always #5 clk = ~clk;
    tlv_irq_ctrl i_tlv_irq_ctrl (.clk(clk), .arst_n(arst_n),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdq),
        .avs_waitrequest(wq), .ext_request_pin_n(pin_n), .events_i(ev),
        .power_fail_irq(pf), .core_i(core), .call_o(call));
    tlv_core_model i_tlv_core_model (.clk(clk), .arst_n(arst_n),
        .call_i(call), .stall(stall), .wr_regs(wrr), .return_from_irq(return_from_irq),
        .core_o(core), .pc_seen(pcs));
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Avalon cycle held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        adr <= a;
        wr  <= w;
        rd  <= !w;
        wd  <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wq !== 1'b0 && k < 20);
        rdat = rdq;
        chk("waitrequest", 32'h0, 32'(wq));
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wl;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (call.load !== 1'b1 && n < 40);
    endtask
    task automatic vcall(input logic [15:0] e);
        wl();
        chk("call seen", 32'h1, 32'(n < 40));
        chk("vector", 32'(e), 32'(call.vector));
    endtask
    task automatic none;
        wl();
        chk("no call", 32'd40, 32'(n));
    endtask
    task automatic rt;
        @(posedge clk) return_from_irq <= 1'b1;
        @(posedge clk) return_from_irq <= 1'b0;
    endtask
    task automatic s_reset;
        bus(0, OFS_FLAG, 0); chk("flag", 0, rdat);
        bus(0, OFS_ENABLE, 0); chk("enable", 0, rdat);
        bus(0, OFS_PRIO, 0); chk("prio", 0, rdat);
        bus(0, OFS_CONFIG, 0); chk("config", 0, rdat);
        bus(0, 8'h20, 0); chk("unmapped", 0, rdat);
    endtask
    task automatic s_edge;
        bus(1, OFS_CONFIG, 32'h3);
        bus(1, OFS_ENABLE, 32'h1FFF);
        @(posedge clk) pin_n[0] <= 1'b0;
        wl(); chk("latency", 6, 32'(n));
        chk("vector", 32'h3, 32'(call.vector));
        chk("push pc", 32'h1234, 32'(pcs));
        bus(0, OFS_FLAG, 0); chk("flag", 0, rdat);
        pin_n[0] <= 1'b1;
        rt();
    endtask
    task automatic s_order;
        logic [15:0] vt [12] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B,
            16'h0023, 16'h002B, 16'h003B, 16'h0043, 16'h004B, 16'h0053,
            16'h005B, 16'h0063};
        int bt [12] = '{0, 1, 2, 3, 5, 7, 8, 10, 11, 12, 13, 14};
        logic [14:0] m;
        m = '0;
        foreach (bt[i]) m[bt[i]] = 1'b1;
        bus(1, OFS_CONFIG, 32'h17);
        bus(1, OFS_FLAG, 32'(m));
        for (int i = 0; i < 12; i++) begin
            vcall(vt[i]);
            if (i < 4 || i == 7 || i == 9) m[bt[i]] = 1'b0;
            bus(0, OFS_FLAG, 0);
            chk("flag", 32'(m), rdat);
            m[bt[i]] = 1'b0;
            bus(1, OFS_FLAG, 32'(m));
            rt();
        end
    endtask
    task automatic s_level;
        bus(1, OFS_CONFIG, 0);
        @(posedge clk) pin_n[1] <= 1'b0;
        vcall(16'h0013);
        bus(0, OFS_FLAG, 0); chk("flag", 32'h4, rdat);
        rt();
        vcall(16'h0013);
        @(posedge clk) pin_n[1] <= 1'b1;
        rt();
        none();
    endtask
    task automatic s_mask;
        bus(1, OFS_ENABLE, 32'h1F7F);
        bus(1, OFS_FLAG, 32'h2);
        none();
        bus(1, OFS_FLAG, 0);
        bus(1, OFS_ENABLE, 32'h11FFF);
        none();
        bus(1, OFS_ENABLE, 32'h11F7F);
        @(posedge clk) pf <= 1'b1;
        vcall(PFI_VECTOR);
        @(posedge clk) pf <= 1'b0;
        rt();
    endtask
    task automatic s_prio;
        bus(1, OFS_ENABLE, 32'h1FFF);
        bus(1, OFS_PRIO, 32'h1);
        bus(1, OFS_CONFIG, 32'h3);
        @(posedge clk) ev.timer0_ovf <= 1'b1;
        @(posedge clk) ev.timer0_ovf <= 1'b0;
        vcall(16'h000B);
        bus(1, OFS_FLAG, 32'h1);
        vcall(16'h0003);
        bus(0, OFS_STATUS, 0); chk("status", 32'h3, rdat);
        bus(1, OFS_FLAG, 32'h8);
        none();
        rt();
        none();
        rt();
        vcall(16'h001B);
        rt();
        wrr <= 1'b1;
        bus(1, OFS_FLAG, 32'h2);
        none();
        @(posedge clk) wrr <= 1'b0;
        stall <= 1'b1;
        none();
        @(posedge clk) stall <= 1'b0;
        vcall(16'h000B);
        rt();
    endtask
    initial begin
        #300000;
        bad_count++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        s_reset();
        s_edge();
        s_order();
        s_level();
        s_mask();
        s_prio();
        close_out();
    end
endmodule
`default_nettype wire
